/* File: ddrat_device.sv */
// controller end: write buffer, per-port target engine and the two-port top with sequencer and calibration
//
// Contract
// - two target ports, 256 and 128 bits
// - shared request; select low read, high write
// - master gives 32-bit first-beat byte address
// - next beat address from kind and size
// - master gives 8-bit beat count
// - master gives 3-bit beat size
// - master gives 2-bit atomic kind
// - 8-bit tag, read or write group
// - request moves when valid and accept high
// - one strobe per byte, 32 or 16
// - master flags final write beat as last
// - master tags write beats with request tag
// - write beat moves when valid and ready
// - response carries tag, held until accepted
// - read data tagged, last on final beat
// - 2-bit status with every read beat
// - read beat moves when valid and ready
// - phy clock from pll, half lane rate
// - x16 or x32 dq, up to 1066 Mbps
// - phy reachable only through the controller
// - calibration bus reads and writes tuning register
// - configure memory after reset before any access
// - sequencer has start and clear inputs
`timescale 1ns/1ps

module ddrat_fifo
	import ddrat_pkg::*;
#(
	parameter int W = 8,
	parameter int D = 16
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic in_ready;
	} ddrat_fifo_s;

	ddrat_fifo_s s, n;
	logic [W-1:0] mem [D];
	logic push, pop;

	assign push = in_valid & s.in_ready;
	assign pop = out_valid & out_ready;
	assign in_ready = s.in_ready;
	assign out_valid = (s.cnt != '0);
	assign out_data = mem[s.rp];

	always_comb
	begin
		n = s;
		if (push)
			n.wp = s.wp + 1'b1;
		if (pop)
			n.rp = s.rp + 1'b1;
		if (push && !pop)
			n.cnt = s.cnt + 1'b1;
		else if (pop && !push)
			n.cnt = s.cnt - 1'b1;
		n.in_ready = (n.cnt != (AW+1)'(D));
	end

	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			s <= '{wp: '0, rp: '0, cnt: '0, in_ready: 1'b1};
		else
			s <= n;

	always_ff @(posedge clk_sys)
		if (push)
			mem[s.wp] <= in_data;
endmodule

module ddrat_target_port
	import ddrat_pkg::*;
#(
	parameter int DW = 256
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// gate from the configuration sequencer
	input wire logic mem_ready,
	// fabric side
	ddrat_axi_if.target bus
);
	localparam int LB = $clog2(DW/8);
	localparam int IW = $clog2(DDRAT_MEM_WORDS);
	localparam int FW = 1 + 8 + DW/8 + DW;

	typedef enum logic [1:0] {PS_IDLE, PS_WDATA, PS_WRESP, PS_RDATA} ddrat_port_e;
	typedef struct packed {
		ddrat_port_e st;
		logic [31:0] addr;
		logic [7:0] len;
		logic [7:0] cnt;
		logic [2:0] size;
		logic [1:0] kind;
		logic [7:0] id;
		logic drain_phase;
		logic req_accept;
		logic bvalid;
		logic [7:0] bid;
		logic rvalid;
		logic [DW-1:0] rdata;
		logic [7:0] rid;
		logic rlast;
		logic [1:0] rresp;
	} ddrat_port_s;

	ddrat_port_s s, n;
	logic [DW-1:0] mem [DDRAT_MEM_WORDS];
	logic f_out_valid, f_out_ready;
	logic [FW-1:0] f_out;
	logic wr_en;
	logic [31:0] beat_next;

	function automatic logic [31:0] next_beat_addr(input logic [31:0] a, input logic [2:0] size,
		input logic [1:0] kind, input logic [7:0] len);
		logic [31:0] inc, wmask;
		inc = 32'h1 << size;
		wmask = (({24'h0, len} + 32'h1) << size) - 32'h1;
		case (kind)
			DDRAT_BURST_FIXED: next_beat_addr = a;
			DDRAT_BURST_WRAP: next_beat_addr = (a & ~wmask) | ((a + inc) & wmask);
			default: next_beat_addr = a + inc;
		endcase
	endfunction

	function automatic logic [IW-1:0] word_idx(input logic [31:0] a);
		word_idx = a[LB+IW-1:LB];
	endfunction

	function automatic logic [1:0] beat_status(input logic [31:0] a);
		beat_status = (a[31:LB+IW] == '0) ? DDRAT_RESP_OKAY : DDRAT_RESP_SLVERR;
	endfunction

	// write beats {last, tag, strobes, data} queue here so the master is not held by the store
	ddrat_fifo #(.W(FW), .D(DDRAT_FIFO_DEPTH)) u_wbuf (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_valid(bus.wvalid),
		.in_ready(bus.wready),
		.in_data({bus.wlast, bus.wid, bus.wstrb, bus.wdata}),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out)
	);

	// store accepts a beat every other cycle, so a fast master really fills the buffer
	assign f_out_ready = (s.st == PS_WDATA) && s.drain_phase;
	assign wr_en = f_out_valid && f_out_ready;
	assign beat_next = next_beat_addr(s.addr, s.size, s.kind, s.len);

	assign bus.shared_req_accept = s.req_accept;
	assign bus.bvalid = s.bvalid;
	assign bus.bid = s.bid;
	assign bus.rvalid = s.rvalid;
	assign bus.rdata = s.rdata;
	assign bus.rid = s.rid;
	assign bus.rlast = s.rlast;
	assign bus.rresp = s.rresp;

	always_comb
	begin
		n = s;
		n.drain_phase = ~s.drain_phase;
		case (s.st)
			PS_IDLE:
			begin
				// no request is taken until the memory is configured
				n.req_accept = mem_ready;
				if (bus.shared_req_valid && s.req_accept)
				begin
					n.req_accept = 1'b0;
					n.addr = bus.shared_req_address;
					n.len = bus.shared_req_beat_count;
					n.size = bus.shared_req_beat_size;
					n.kind = bus.shared_req_burst_kind;
					n.id = bus.shared_req_tag;
					n.cnt = 8'h00;
					if (bus.access_direction_sel == DDRAT_DIR_WRITE)
						n.st = PS_WDATA;
					else
					begin
						n.st = PS_RDATA;
						n.rvalid = 1'b1;
						n.rdata = mem[word_idx(bus.shared_req_address)];
						n.rid = bus.shared_req_tag;
						n.rlast = (bus.shared_req_beat_count == 8'h00);
						n.rresp = beat_status(bus.shared_req_address);
					end
				end
			end
			PS_WDATA:
				if (wr_en)
				begin
					n.addr = beat_next;
					n.cnt = s.cnt + 8'h01;
					if (f_out[FW-1])
					begin
						n.st = PS_WRESP;
						n.bvalid = 1'b1;
						n.bid = s.id;
					end
				end
			PS_WRESP:
				if (bus.bready)
				begin
					n.bvalid = 1'b0;
					n.st = PS_IDLE;
				end
			PS_RDATA:
				if (bus.rready)
				begin
					if (s.rlast)
					begin
						n.rvalid = 1'b0;
						n.rlast = 1'b0;
						n.st = PS_IDLE;
					end
					else
					begin
						n.addr = beat_next;
						n.cnt = s.cnt + 8'h01;
						n.rdata = mem[word_idx(beat_next)];
						n.rlast = (s.cnt + 8'h01 == s.len);
						n.rresp = beat_status(beat_next);
					end
				end
			default:
				n.st = PS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			s <= '0;
		else
			s <= n;

	// byte lanes outside the strobe keep their contents; out-of-range beats are dropped
	always_ff @(posedge clk_sys)
		if (wr_en && beat_status(s.addr) == DDRAT_RESP_OKAY)
			for (int b = 0; b < DW/8; b++)
				if (f_out[DW+b])
					mem[word_idx(s.addr)][b*8 +: 8] <= f_out[b*8 +: 8];
endmodule

module ddrat_device
	import ddrat_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// target ports: port 0 carries 256 bits, port 1 carries 128 bits
	ddrat_axi_if.target port0,
	ddrat_axi_if.target port1,
	// memory reset and configuration sequencer
	input wire logic mem_rst_b,
	input wire logic init_sequencer_go,
	input wire logic init_sequencer_clear,
	output logic init_done,
	// calibration bus, open drain on data
	input wire logic cal_scl_in,
	input wire logic cal_sda_in,
	output logic cal_sda_oe,
	// phy tuning byte
	output logic [7:0] cal_phy_tune
);
	typedef enum logic [1:0] {IS_HOLD, IS_CONFIG, IS_DONE} ddrat_init_e;
	typedef enum logic [2:0] {CS_IDLE, CS_ADDR, CS_AACK, CS_WDAT, CS_DACK, CS_RDAT} ddrat_cal_e;
	typedef struct packed {
		logic [4:0] sy1;
		logic [4:0] sy2;
		logic scl_d;
		logic sda_d;
		ddrat_init_e ist;
		logic [15:0] icnt;
		logic done;
		ddrat_cal_e cst;
		logic [3:0] bits;
		logic [7:0] sh;
		logic rd;
		logic sda_oe;
		logic [7:0] tune;
	} ddrat_dev_s;

	ddrat_dev_s s, n;
	logic m_rst_b, go, clr, scl, sda;

	assign {m_rst_b, go, clr, scl, sda} = s.sy2;
	assign init_done = s.done;
	assign cal_sda_oe = s.sda_oe;
	assign cal_phy_tune = s.tune;

	// the phy has no port of its own here: every access goes through these engines
	ddrat_target_port #(.DW(DDRAT_P0_DW)) u_port0 (.clk_sys(clk_sys), .rst_b(rst_b), .mem_ready(s.done),
		.bus(port0));
	ddrat_target_port #(.DW(DDRAT_P1_DW)) u_port1 (.clk_sys(clk_sys), .rst_b(rst_b), .mem_ready(s.done),
		.bus(port1));

	always_comb
	begin
		n = s;
		n.sy1 = {mem_rst_b, init_sequencer_go, init_sequencer_clear, cal_scl_in, cal_sda_in};
		n.sy2 = s.sy1;
		n.scl_d = scl;
		n.sda_d = sda;
		// configuration sequencer
		if (!m_rst_b || clr)
			n.ist = IS_HOLD;
		else
			case (s.ist)
				IS_HOLD:
					if (go)
					begin
						n.ist = IS_CONFIG;
						n.icnt = 16'h0000;
					end
				IS_CONFIG:
				begin
					n.icnt = s.icnt + 16'h0001;
					if (s.icnt == DDRAT_INIT_CYC - 16'h0001)
						n.ist = IS_DONE;
				end
				IS_DONE:
					n.ist = IS_DONE;
				default:
					n.ist = IS_HOLD;
			endcase
		n.done = (n.ist == IS_DONE);
		// calibration slave: one tuning byte, read or written
		if (s.scl_d && scl && s.sda_d && !sda)
		begin
			n.cst = CS_ADDR;
			n.bits = 4'h0;
			n.sda_oe = 1'b0;
		end
		else if (s.scl_d && scl && !s.sda_d && sda)
		begin
			n.cst = CS_IDLE;
			n.sda_oe = 1'b0;
		end
		else if (!s.scl_d && scl)
		begin
			if (s.cst == CS_ADDR || s.cst == CS_WDAT)
			begin
				n.sh = {s.sh[6:0], sda};
				n.bits = s.bits + 4'h1;
			end
			else if (s.cst == CS_RDAT)
			begin
				n.bits = s.bits + 4'h1;
				if (s.bits == DDRAT_CAL_BITS && sda)
					n.cst = CS_IDLE;
			end
		end
		else if (s.scl_d && !scl)
			case (s.cst)
				CS_ADDR:
					if (s.bits == DDRAT_CAL_BITS)
					begin
						n.cst = (s.sh[7:1] == DDRAT_CAL_ADDR) ? CS_AACK : CS_IDLE;
						n.sda_oe = (s.sh[7:1] == DDRAT_CAL_ADDR);
						n.rd = s.sh[0];
					end
				CS_AACK, CS_DACK:
				begin
					n.bits = 4'h0;
					n.sh = s.tune;
					n.cst = s.rd ? CS_RDAT : CS_WDAT;
					n.sda_oe = s.rd && !s.tune[7];
				end
				CS_WDAT:
					if (s.bits == DDRAT_CAL_BITS)
					begin
						n.tune = s.sh;
						n.cst = CS_DACK;
						n.sda_oe = 1'b1;
					end
				CS_RDAT:
					if (s.bits == DDRAT_CAL_BITS + 4'h1)
					begin
						n.bits = 4'h0;
						n.sh = s.tune;
						n.sda_oe = !s.tune[7];
					end
					else if (s.bits == DDRAT_CAL_BITS)
						n.sda_oe = 1'b0;
					else
					begin
						n.sh = {s.sh[6:0], 1'b0};
						n.sda_oe = !s.sh[6];
					end
				default:
					n.sda_oe = 1'b0;
			endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			s <= '{sy1: DDRAT_SYNC_RST, sy2: DDRAT_SYNC_RST, scl_d: 1'b1, sda_d: 1'b1, ist: IS_HOLD,
				cst: CS_IDLE, tune: DDRAT_CAL_TUNE_RST, default: '0};
		else
			s <= n;
endmodule

/* File: ddrat_pkg.sv */
// shared constants and encodings for the two-port ddr target and its fabric master
package ddrat_pkg;

	// port data paths and field widths
	localparam int DDRAT_P0_DW = 256;
	localparam int DDRAT_P1_DW = 128;
	localparam int DDRAT_ADDR_W = 32;
	localparam int DDRAT_ID_W = 8;
	localparam int DDRAT_LEN_W = 8;

	// direction select on the shared request channel
	localparam logic DDRAT_DIR_READ = 1'h0;
	localparam logic DDRAT_DIR_WRITE = 1'h1;

	// burst kinds
	localparam logic [1:0] DDRAT_BURST_FIXED = 2'h0;
	localparam logic [1:0] DDRAT_BURST_INCR = 2'h1;
	localparam logic [1:0] DDRAT_BURST_WRAP = 2'h2;

	// read status codes
	localparam logic [1:0] DDRAT_RESP_OKAY = 2'h0;
	localparam logic [1:0] DDRAT_RESP_SLVERR = 2'h2;

	// write path buffer and backing store depth per port
	localparam int DDRAT_FIFO_DEPTH = 16;
	localparam int DDRAT_MEM_WORDS = 64;

	// memory interface figures, kept for reference by the phy side
	localparam int DDRAT_DQ_W_NARROW = 16;
	localparam int DDRAT_DQ_W_WIDE = 32;
	localparam int DDRAT_LANE_MBPS_MAX = 1066;
	localparam int DDRAT_PHY_CLK_DIV = 2;

	// configuration sequencer run time
	localparam int DDRAT_CLK_PERIOD_NS = 10;
	localparam int DDRAT_INIT_TIME_NS = 2000;
	localparam logic [15:0] DDRAT_INIT_CYC = 16'((DDRAT_INIT_TIME_NS + DDRAT_CLK_PERIOD_NS - 1) / DDRAT_CLK_PERIOD_NS);

	// calibration bus
	localparam logic [6:0] DDRAT_CAL_ADDR = 7'h2A;
	localparam logic [7:0] DDRAT_CAL_TUNE_RST = 8'h00;
	localparam logic [3:0] DDRAT_CAL_BITS = 4'h8;

	// synchroniser reset pattern: {mem_rst_b, go, clear, scl, sda}
	localparam logic [4:0] DDRAT_SYNC_RST = 5'h03;

endpackage

/* File: ddrat_axi_if.sv */
// channel bundle between one fabric master and one target port
`timescale 1ns/1ps
interface ddrat_axi_if #(parameter int DW = 256);
	// shared request channel
	logic access_direction_sel;
	logic [31:0] shared_req_address;
	logic [1:0] shared_req_burst_kind;
	logic [7:0] shared_req_tag;
	logic [7:0] shared_req_beat_count;
	logic [1:0] shared_req_atomic_kind;
	logic [2:0] shared_req_beat_size;
	logic shared_req_valid;
	logic shared_req_accept;
	// write data
	logic [DW-1:0] wdata;
	logic [DW/8-1:0] wstrb;
	logic [7:0] wid;
	logic wlast;
	logic wvalid;
	logic wready;
	// write response
	logic [7:0] bid;
	logic bvalid;
	logic bready;
	// read data
	logic [DW-1:0] rdata;
	logic [7:0] rid;
	logic rlast;
	logic [1:0] rresp;
	logic rvalid;
	logic rready;

	modport target (
		input access_direction_sel, shared_req_address, shared_req_burst_kind, shared_req_tag,
		input shared_req_beat_count, shared_req_atomic_kind, shared_req_beat_size, shared_req_valid,
		output shared_req_accept,
		input wdata, wstrb, wid, wlast, wvalid,
		output wready,
		output bid, bvalid,
		input bready,
		output rdata, rid, rlast, rresp, rvalid,
		input rready
	);

	modport master (
		output access_direction_sel, shared_req_address, shared_req_burst_kind, shared_req_tag,
		output shared_req_beat_count, shared_req_atomic_kind, shared_req_beat_size, shared_req_valid,
		input shared_req_accept,
		output wdata, wstrb, wid, wlast, wvalid,
		input wready,
		input bid, bvalid,
		output bready,
		input rdata, rid, rlast, rresp, rvalid,
		output rready
	);
endinterface

/* File: ddrat_master.sv */
// fabric end: turns user commands and data into target-port traffic
`timescale 1ns/1ps
module ddrat_master
	import ddrat_pkg::*;
#(
	parameter int DW = 256
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// target port
	ddrat_axi_if.master bus,
	// user command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [31:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	input wire logic [2:0] cmd_size,
	input wire logic [1:0] cmd_burst,
	input wire logic [1:0] cmd_lock,
	input wire logic [7:0] cmd_id,
	// user write data
	input wire logic wd_valid,
	output logic wd_ready,
	input wire logic [DW-1:0] wd_data,
	input wire logic [DW/8-1:0] wd_strb,
	// user write completion
	output logic wr_done,
	output logic [7:0] wr_done_id,
	// user read data
	output logic rd_valid,
	output logic [DW-1:0] rd_data,
	output logic [7:0] rd_id,
	output logic rd_last,
	output logic [1:0] rd_resp
);
	typedef enum logic [2:0] {MS_IDLE, MS_ADDR, MS_WDAT, MS_WRESP, MS_RDAT} ddrat_mst_e;
	typedef struct packed {
		ddrat_mst_e st;
		logic cmd_ready;
		logic dir;
		logic [31:0] addr;
		logic [7:0] len;
		logic [2:0] size;
		logic [1:0] burst;
		logic [1:0] lock;
		logic [7:0] id;
		logic avalid;
		logic [7:0] beats;
		logic wd_ready;
		logic wvalid;
		logic [DW-1:0] wdata;
		logic [DW/8-1:0] wstrb;
		logic wlast;
		logic bready;
		logic rready;
		logic wr_done;
		logic [7:0] wr_done_id;
		logic rd_valid;
		logic [DW-1:0] rd_data;
		logic [7:0] rd_id;
		logic rd_last;
		logic [1:0] rd_resp;
	} ddrat_mst_s;

	ddrat_mst_s s, n;

	assign bus.access_direction_sel = s.dir;
	assign bus.shared_req_address = s.addr;
	assign bus.shared_req_beat_count = s.len;
	assign bus.shared_req_beat_size = s.size;
	assign bus.shared_req_burst_kind = s.burst;
	assign bus.shared_req_atomic_kind = s.lock;
	assign bus.shared_req_tag = s.id;
	assign bus.shared_req_valid = s.avalid;
	assign bus.wvalid = s.wvalid;
	assign bus.wdata = s.wdata;
	assign bus.wstrb = s.wstrb;
	assign bus.wlast = s.wlast;
	assign bus.wid = s.id;
	assign bus.bready = s.bready;
	assign bus.rready = s.rready;
	assign cmd_ready = s.cmd_ready;
	assign wd_ready = s.wd_ready;
	assign wr_done = s.wr_done;
	assign wr_done_id = s.wr_done_id;
	assign rd_valid = s.rd_valid;
	assign rd_data = s.rd_data;
	assign rd_id = s.rd_id;
	assign rd_last = s.rd_last;
	assign rd_resp = s.rd_resp;

	always_comb
	begin
		n = s;
		n.wr_done = 1'b0;
		n.rd_valid = 1'b0;
		case (s.st)
			MS_IDLE:
			begin
				n.cmd_ready = 1'b1;
				if (cmd_valid && s.cmd_ready)
				begin
					n.cmd_ready = 1'b0;
					n.dir = cmd_write ? DDRAT_DIR_WRITE : DDRAT_DIR_READ;
					n.addr = cmd_addr;
					n.len = cmd_len;
					n.size = cmd_size;
					n.burst = cmd_burst;
					n.lock = cmd_lock;
					n.id = cmd_id;
					n.avalid = 1'b1;
					n.st = MS_ADDR;
				end
			end
			MS_ADDR:
				// request and control stay steady until the target takes them
				if (bus.shared_req_accept)
				begin
					n.avalid = 1'b0;
					n.beats = 8'h00;
					n.st = (s.dir == DDRAT_DIR_WRITE) ? MS_WDAT : MS_RDAT;
					n.wd_ready = (s.dir == DDRAT_DIR_WRITE);
					n.rready = (s.dir == DDRAT_DIR_READ);
				end
			MS_WDAT:
				// one beat slot: half rate, but every output stays registered
				if (s.wvalid)
				begin
					if (bus.wready)
					begin
						n.wvalid = 1'b0;
						n.beats = s.beats + 8'h01;
						if (s.wlast)
						begin
							n.st = MS_WRESP;
							n.bready = 1'b1;
						end
						else
							n.wd_ready = 1'b1;
					end
				end
				else if (wd_valid && s.wd_ready)
				begin
					n.wd_ready = 1'b0;
					n.wvalid = 1'b1;
					n.wdata = wd_data;
					n.wstrb = wd_strb;
					n.wlast = (s.beats == s.len);
				end
			MS_WRESP:
				if (bus.bvalid)
				begin
					n.bready = 1'b0;
					n.wr_done = 1'b1;
					n.wr_done_id = bus.bid;
					n.st = MS_IDLE;
				end
			MS_RDAT:
				if (bus.rvalid)
				begin
					n.rd_valid = 1'b1;
					n.rd_data = bus.rdata;
					n.rd_id = bus.rid;
					n.rd_last = bus.rlast;
					n.rd_resp = bus.rresp;
					if (bus.rlast)
					begin
						n.rready = 1'b0;
						n.st = MS_IDLE;
					end
				end
			default:
				n.st = MS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
			s <= '0;
		else
			s <= n;
endmodule

/* File: ddrat_chk.sv */
// assertions on the port 0 channels between the fabric master and the controller
`timescale 1ns/1ps
module ddrat_chk
	import ddrat_pkg::*;
#(
	parameter int DW = 256
)(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// request channel
	input wire logic access_direction_sel,
	input wire logic [31:0] shared_req_address,
	input wire logic [7:0] shared_req_tag,
	input wire logic [7:0] shared_req_beat_count,
	input wire logic shared_req_valid,
	input wire logic shared_req_accept,
	// write channels
	input wire logic wlast,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [7:0] bid,
	input wire logic bvalid,
	input wire logic bready,
	// read channel
	input wire logic [7:0] rid,
	input wire logic rlast,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	localparam int HI = $clog2(DW / 8) + 6;
	logic [7:0] len_q;
	logic [7:0] tag_q;
	logic [7:0] beat_n;

	// read beat counter of the burst in flight, restarted at every request take
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			len_q <= 8'h00;
			tag_q <= 8'h00;
			beat_n <= 8'h00;
		end
		else if (shared_req_valid && shared_req_accept)
		begin
			len_q <= shared_req_beat_count;
			tag_q <= shared_req_tag;
			beat_n <= 8'h00;
		end
		else if (rvalid && rready)
			beat_n <= beat_n + 8'h01;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence req_take;
		shared_req_valid && shared_req_accept;
	endsequence
	sequence read_take;
		req_take ##0 access_direction_sel == DDRAT_DIR_READ;
	endsequence
	sequence last_beat_in;
		wvalid && wready && wlast;
	endsequence

	req_hold_a: assert property (shared_req_valid && !shared_req_accept |=> shared_req_valid)
		else $error("request withdrawn before accept");
	accept_drop_a: assert property (req_take |=> !shared_req_accept)
		else $error("accept still high after a take");
	read_first_a: assert property (read_take |=> rvalid && rid == $past(shared_req_tag))
		else $error("first read beat missing or mistagged");
	read_status_a: assert property (read_take |=>
		rresp == ((($past(shared_req_address) >> HI) != 32'h0) ? DDRAT_RESP_SLVERR : DDRAT_RESP_OKAY))
		else $error("wrong read status on first beat");
	rlast_count_a: assert property (rvalid |-> rlast == (beat_n == len_q))
		else $error("read last on wrong beat");
	read_end_a: assert property (rvalid && rready && rlast |=> !rvalid)
		else $error("read valid after last beat");
	resp_due_a: assert property (last_beat_in |-> ##[1:60] bvalid)
		else $error("no write response after last beat");
	resp_tag_a: assert property (bvalid |-> bid == tag_q)
		else $error("write response tag wrong");
	resp_once_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write response held after accept");
endmodule

/* File: ddr_axi_target_ports_test.sv */
// self-checking bench: fabric master and controller joined on port 0, buffer fill driven on port 1
`timescale 1ns/1ps
module ddr_axi_target_ports_test
	import ddrat_pkg::*;
;
	logic clk_sys = 1'b0, rst_b = 1'b0, mem_rst_b = 1'b0, init_sequencer_go = 1'b0, init_sequencer_clear = 1'b0;
	logic init_done, cal_sda_oe, cmd_ready, wd_ready, wr_done, rd_valid, rd_last;
	logic cmd_valid = 1'b0, cmd_write = 1'b0, wd_valid = 1'b0;
	logic [31:0] cmd_addr = 32'h0, wd_strb = 32'h0, rng = 32'h00012456, a;
	logic [7:0] cmd_len = 8'h0, cmd_id = 8'h0, wr_done_id, rd_id, ln;
	logic [2:0] cmd_size = 3'h5;
	logic [1:0] cmd_burst = 2'h1, cmd_lock = 2'h0, rd_resp;
	logic [255:0] wd_data = 256'h0, rd_data;
	logic [255:0] model [64];
	int fail_count = 0, cmp_count = 0;
	ddrat_axi_if #(.DW(256)) p0();
	ddrat_axi_if #(.DW(128)) p1();

	ddrat_master #(.DW(256)) i_ddrat_master (.clk_sys(clk_sys), .rst_b(rst_b), .bus(p0), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_size(cmd_size),
		.cmd_burst(cmd_burst), .cmd_lock(cmd_lock), .cmd_id(cmd_id), .wd_valid(wd_valid), .wd_ready(wd_ready),
		.wd_data(wd_data), .wd_strb(wd_strb), .wr_done(wr_done), .wr_done_id(wr_done_id), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_id(rd_id), .rd_last(rd_last), .rd_resp(rd_resp));
	// the data line is pulled up, so it is low only while the device pulls it
	ddrat_device i_ddrat_device (.clk_sys(clk_sys), .rst_b(rst_b), .port0(p0), .port1(p1), .mem_rst_b(mem_rst_b),
		.init_sequencer_go(init_sequencer_go), .init_sequencer_clear(init_sequencer_clear), .init_done(init_done),
		.cal_scl_in(1'b1), .cal_sda_in(!cal_sda_oe), .cal_sda_oe(cal_sda_oe), .cal_phy_tune());
	ddrat_chk #(.DW(256)) i_ddrat_chk (.clk_sys(clk_sys), .rst_b(rst_b),
		.access_direction_sel(p0.access_direction_sel), .shared_req_address(p0.shared_req_address),
		.shared_req_tag(p0.shared_req_tag), .shared_req_beat_count(p0.shared_req_beat_count),
		.shared_req_valid(p0.shared_req_valid), .shared_req_accept(p0.shared_req_accept), .wlast(p0.wlast),
		.wvalid(p0.wvalid), .wready(p0.wready), .bid(p0.bid), .bvalid(p0.bvalid), .bready(p0.bready), .rid(p0.rid),
		.rlast(p0.rlast), .rresp(p0.rresp), .rvalid(p0.rvalid), .rready(p0.rready));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// byte address of beat i; wrap assumes a power-of-two beat count
	function automatic logic [31:0] beat_addr(input logic [31:0] s, input logic [1:0] k, input logic [7:0] len, int i);
		logic [31:0] win;
		win = (32'(len) + 32'h1) << 5;
		if (k == DDRAT_BURST_FIXED)
			return s;
		if (k == DDRAT_BURST_WRAP)
			return (s & ~(win - 32'h1)) + ((s + (32'(i) << 5)) & (win - 32'h1));
		return s + (32'(i) << 5);
	endfunction

	task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wait_hi(ref logic s, input string what);
		int k;
		k = 0;
		while (s !== 1'b1 && k < 500)
		begin
			@(negedge clk_sys);
			k++;
		end
		check(what, 256'(s), 256'h1);
	endtask

	task automatic send_cmd(input logic w, input logic [31:0] s, input logic [1:0] k, input logic [7:0] len, id);
		cmd_write = w;
		cmd_addr = s;
		cmd_burst = k;
		cmd_len = len;
		cmd_id = id;
		cmd_lock = rng[1:0];
		cmd_size = (k == DDRAT_BURST_FIXED) ? rng[4:2] : 3'h5;
		cmd_valid = 1'b1;
		wait_hi(cmd_ready, "cmd_ready");
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask

	task automatic p1_req(input logic w, input logic [7:0] id);
		p1.access_direction_sel = w;
		p1.shared_req_tag = id;
		p1.shared_req_atomic_kind = rng[1:0];
		p1.shared_req_valid = 1'b1;
		wait_hi(p1.shared_req_accept, "p1_accept");
		@(negedge clk_sys);
		p1.shared_req_valid = 1'b0;
	endtask

	task automatic do_write(input logic [31:0] s, input logic [7:0] len, id, input logic full);
		logic [31:0] ba;
		send_cmd(DDRAT_DIR_WRITE, s, DDRAT_BURST_INCR, len, id);
		for (int i = 0; i <= len; i++)
		begin
			ba = beat_addr(s, DDRAT_BURST_INCR, len, i);
			for (int j = 0; j < 8; j++)
			begin
				rng = xs(rng);
				wd_data[j*32 +: 32] = rng;
			end
			rng = xs(rng);
			wd_strb = full ? 32'hFFFFFFFF : rng;
			for (int b = 0; b < 32; b++)
				if (wd_strb[b] && ba[31:11] == 21'h0)
					model[ba[10:5]][b*8 +: 8] = wd_data[b*8 +: 8];
			wd_valid = 1'b1;
			wait_hi(wd_ready, "wd_ready");
			@(negedge clk_sys);
			wd_valid = 1'b0;
			if (i < len)
				@(negedge clk_sys);
		end
		wait_hi(wr_done, "wr_done");
		check("wr_done_id", 256'(wr_done_id), 256'(id));
	endtask

	task automatic do_read(input logic [31:0] s, input logic [1:0] k, input logic [7:0] len, id);
		logic [31:0] ba;
		send_cmd(DDRAT_DIR_READ, s, k, len, id);
		for (int i = 0; i <= len; i++)
		begin
			ba = beat_addr(s, k, len, i);
			wait_hi(rd_valid, "rd_valid");
			check("rd_id", 256'(rd_id), 256'(id));
			check("rd_last", 256'(rd_last), 256'(i == int'(len)));
			check("rd_resp", 256'(rd_resp), 256'(ba[31:11] != 0 ? DDRAT_RESP_SLVERR : DDRAT_RESP_OKAY));
			if (ba[31:11] == 21'h0)
				check("rd_data", rd_data, model[ba[10:5]]);
			@(negedge clk_sys);
		end
	endtask

	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	initial
	begin
		#300000;
		fail_count++;
		report_and_stop;
	end

	initial
	begin
		p1.shared_req_valid = 1'b0;
		p1.wvalid = 1'b0;
		p1.bready = 1'b1;
		p1.rready = 1'b1;
		p1.shared_req_address = 32'h0;
		p1.shared_req_burst_kind = DDRAT_BURST_INCR;
		p1.shared_req_beat_count = 8'h0F;
		p1.shared_req_beat_size = 3'h4;
		repeat (12) @(negedge clk_sys);
		rst_b = 1'b1;
		mem_rst_b = 1'b1;
		init_sequencer_go = 1'b1;
		wait_hi(init_done, "init_done");
		$display("test start done");
		do_write(32'h0, 8'h3F, 8'h11, 1'b1);
		for (int t = 0; t < 6; t++)
		begin
			rng = xs(rng);
			a = {21'h0, rng[10:5], 5'h0};
			ln = 8'(rng[14:12]);
			do_write(a, ln, rng[23:16], 1'b0);
			do_read(a, DDRAT_BURST_INCR, ln, rng[31:24]);
		end
		do_write(32'h000007E0, 8'h01, 8'hFE, 1'b0);
		do_read(32'h000007E0, DDRAT_BURST_INCR, 8'h01, 8'h00);
		do_read(32'h80000000, DDRAT_BURST_FIXED, 8'h00, 8'h5A);
		for (int k = 0; k < 4; k++)
			do_read(32'h00000060, 2'(k), 8'h03, 8'(k));
		$display("test bursts done");
		for (int c = 0; c < 2; c++)
		begin
			init_sequencer_clear = (c == 0);
			mem_rst_b = (c == 0);
			repeat (6) @(negedge clk_sys);
			check("init_done", 256'(init_done), 256'h0);
			check("req_accept", 256'(p0.shared_req_accept), 256'h0);
			init_sequencer_clear = 1'b0;
			mem_rst_b = 1'b1;
			wait_hi(init_done, "init_done");
		end
		$display("test restart done");
		// beats before the request fill the buffer, since nothing drains it while idle
		p1.wstrb = 16'hFFFF;
		p1.wid = 8'h3C;
		p1.wvalid = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			p1.wdata = 128'(i);
			p1.wlast = (i == 15);
			@(negedge clk_sys);
		end
		check("fifo_full", 256'(p1.wready), 256'h0);
		p1.wvalid = 1'b0;
		p1_req(DDRAT_DIR_WRITE, 8'h3C);
		wait_hi(p1.bvalid, "p1_bvalid");
		check("p1_bid", 256'(p1.bid), 256'h3C);
		@(negedge clk_sys);
		p1_req(DDRAT_DIR_READ, 8'hC3);
		for (int i = 0; i < 16; i++)
		begin
			check("p1_rdata", 256'(p1.rdata), 256'(i));
			check("p1_rlast", 256'(p1.rlast), 256'(i == 15));
			@(negedge clk_sys);
		end
		check("fifo_empty", 256'(p1.wready), 256'h1);
		$display("test buffer done");
		report_and_stop;
	end
endmodule
